//--- shared/pscm_defs.vh
// Constants for the PHY scan monitor and its management frame engine
`ifndef PSCM_DEFS_VH
`define PSCM_DEFS_VH

// ---------------------------------------------------------------
// Clock and management clock timing
// ---------------------------------------------------------------
`define PSCM_CORE_MHZ       250
`define PSCM_MDC_MAX_MHZ    25
// Least half period of the management clock, rounded up
`define PSCM_MDC_MIN_HALF   (((`PSCM_CORE_MHZ + `PSCM_MDC_MAX_MHZ - 1) / `PSCM_MDC_MAX_MHZ + 1) / 2)
`define PSCM_DIV_W          8

// ---------------------------------------------------------------
// Frame layout, one bit position per management clock
// ---------------------------------------------------------------
`define PSCM_PRE_ONES       32'hFFFF_FFFF
`define PSCM_HDR_BITS       46
`define PSCM_POS_TA_LAST    6'h2F
`define PSCM_POS_DATA_FIRST 6'h30
`define PSCM_POS_LAST       6'h3F

// ---------------------------------------------------------------
// Start and operation codes
// ---------------------------------------------------------------
`define PSCM_ST_C22         2'h1
`define PSCM_ST_C45         2'h0
`define PSCM_OP_C22_READ    2'h2
`define PSCM_OP_C45_READ    2'h3
`define PSCM_OP_C45_RDINC   2'h2

// ---------------------------------------------------------------
// Result register reset values and the one-hot PHY select base
// ---------------------------------------------------------------
`define PSCM_MATCH_RST      32'hFFFF_FFFF
`define PSCM_VALID_RST      32'h0000_0000
`define PSCM_ONE_HOT_PHY    32'h0000_0001

`endif

//--- rtl/pscm_mdio_frame.v
// Management frame engine: one read frame on the MDC and MDIO pins
`default_nettype none
`include "pscm_defs.vh"

module pscm_mdio_frame #(
   parameter DIV_W = `PSCM_DIV_W
) (
   input  wire             i_clk,       // Core clock
   input  wire             i_srst,      // Synchronous reset, high
   input  wire             i_ce,        // Clock enable, freezes state
   input  wire             i_start,     // Start one frame, pulse
   input  wire [DIV_W-1:0] i_half,      // MDC half period in cycles
   input  wire [1:0]       i_st,        // Start code of the frame
   input  wire [1:0]       i_op,        // Operation code of the frame
   input  wire [4:0]       i_phy,       // PHY address
   input  wire [4:0]       i_reg,       // Register address
   input  wire             i_mdio_in,   // Data line level
   output reg              o_busy,      // Frame in progress
   output reg              o_done,      // Frame finished, pulse
   output reg  [15:0]      o_rdata,     // Read data
   output reg              o_ok,        // Turnaround seen low
   output reg              o_mdc,       // Management clock
   output reg              o_mdio_out,  // Data line drive value
   output reg              o_mdio_oe    // Data line drive enable
);

   // ------------------------------------------------------------
   // Frame header and bit position
   // ------------------------------------------------------------
   wire [`PSCM_HDR_BITS-1:0] hdr;
   reg  [`PSCM_HDR_BITS-1:0] hdr_reg;
   reg  [5:0]                pos_reg;
   reg  [DIV_W-1:0]          cnt_reg;
   wire [5:0]                pos_next;

   assign hdr      = {`PSCM_PRE_ONES, i_st, i_op, i_phy, i_reg};
   assign pos_next = pos_reg + 6'h01;

   // ------------------------------------------------------------
   // Clock divider, shifting and sampling on the falling edge
   // ------------------------------------------------------------
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_busy     <= 1'b0;
         o_done     <= 1'b0;
         o_rdata    <= 16'h0000;
         o_ok       <= 1'b0;
         o_mdc      <= 1'b0;
         o_mdio_out <= 1'b0;
         o_mdio_oe  <= 1'b0;
         hdr_reg    <= {`PSCM_HDR_BITS{1'b0}};
         pos_reg    <= 6'h00;
         cnt_reg    <= {DIV_W{1'b0}};
      end else if (i_ce) begin
         o_done <= 1'b0;
         if (!o_busy) begin
            if (i_start) begin
               // First bit driven while MDC is low
               o_busy     <= 1'b1;
               o_ok       <= 1'b0;
               o_mdc      <= 1'b0;
               hdr_reg    <= {hdr[`PSCM_HDR_BITS-2:0], 1'b0};
               o_mdio_out <= hdr[`PSCM_HDR_BITS-1];
               o_mdio_oe  <= 1'b1;                         // RQ16
               pos_reg    <= 6'h00;
               cnt_reg    <= {DIV_W{1'b0}};
            end
         end else if (cnt_reg >= i_half - 1'b1) begin
            cnt_reg <= {DIV_W{1'b0}};
            if (!o_mdc) begin
               o_mdc <= 1'b1;                              // RQ17
            end else begin
               // Falling edge: sample the bit just held, drive the next
               o_mdc <= 1'b0;                              // RQ16
               if (pos_reg == `PSCM_POS_TA_LAST)
                  o_ok <= ~i_mdio_in;
               if (pos_reg >= `PSCM_POS_DATA_FIRST)
                  o_rdata <= {o_rdata[14:0], i_mdio_in};
               if (pos_next < `PSCM_HDR_BITS) begin
                  o_mdio_out <= hdr_reg[`PSCM_HDR_BITS-1];
                  hdr_reg    <= {hdr_reg[`PSCM_HDR_BITS-2:0], 1'b0};
               end else begin
                  // Released for turnaround, read data and idle
                  o_mdio_out <= 1'b0;
                  o_mdio_oe  <= 1'b0;                      // RQ16
               end
               pos_reg <= pos_next;
               if (pos_reg == `PSCM_POS_LAST) begin
                  o_busy <= 1'b0;
                  o_done <= 1'b1;
               end
            end
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

endmodule // pscm_mdio_frame

`default_nettype wire

//--- rtl/pscm_scan_monitor.v
// PHY scan monitor: repeated masked register checks over the PHY range
// Summary of operation
// RQ1: While scanning, read and check one register repeatedly
// RQ2: Visit PHYs in order from low to high
// RQ3: Register address comes from the command field
// RQ4: Scan enable with read operation starts scanning
// RQ5: One-pass option stops after one full range
// RQ6: Other command fields ignored while scanning
// RQ7: Masked differing bit records a PHY mismatch
// RQ8: Mask bit zero never causes a mismatch
// RQ9: Latest result bit per PHY, zero on mismatch
// RQ10: Latest valid bit per PHY per completed read
// RQ11: Sticky bit cleared on mismatch until read
// RQ12: Sticky read returns contents then sets all ones
// RQ13: Interrupt raised when any PHY mismatches
// RQ14: Each controller drives its own interrupt line
// RQ15: Sticky read clears interrupt with sticky bits
// RQ16: Data changed and sampled on MDC falling edge
// RQ17: Programmable divider keeps MDC at most 25 MHz
// RQ18: Clause 22 default, Clause 45 by start code
// RQ19: Without one-pass, wrap to low bound continuously
`default_nettype none
`include "pscm_defs.vh"

module pscm_scan_monitor #(
   parameter DIV_W = `PSCM_DIV_W
) (
   input  wire             i_clk,              // Core clock, 250 MHz
   input  wire             i_srst,             // Synchronous reset, high
   input  wire             i_ce,               // Clock enable
   input  wire             i_scan_enable,      // Scan enable field
   input  wire             i_one_pass,         // One-pass option
   input  wire [1:0]       i_operation_code,   // Operation field
   input  wire [1:0]       i_frame_start_code, // Start field
   input  wire [4:0]       i_scan_reg_addr,    // Register address field
   input  wire [4:0]       i_phy_low,          // Low bound of range
   input  wire [4:0]       i_phy_high,         // High bound of range
   input  wire [15:0]      i_expected_value,   // Expected value
   input  wire [15:0]      i_compare_mask,     // Compare mask
   input  wire [DIV_W-1:0] i_clock_divider,    // MDC divider
   input  wire             i_sticky_rd,        // Sticky read, pulse
   input  wire             i_mdio_in,          // Data line level
   output reg  [31:0]      o_scan_latest_match,// Latest results
   output reg  [31:0]      o_scan_latest_valid,// Latest read valid
   output reg  [31:0]      o_scan_sticky_match,// Sticky results
   output reg              o_irq,              // Scan interrupt
   output reg              o_scan_active,      // Scan running
   output wire             o_mdc,              // Management clock
   output wire             o_mdio_out,         // Data drive value
   output wire             o_mdio_oe           // Data drive enable
);

   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   localparam [2:0] S_IDLE   = 3'b001;
   localparam [2:0] S_LAUNCH = 3'b010;
   localparam [2:0] S_WAIT   = 3'b100;

   // Floor of the MDC half period, kept 32 bits wide for compares
   localparam [31:0] MIN_HALF_W = `PSCM_MDC_MIN_HALF;

   reg  [2:0]       state_reg;
   reg  [2:0]       state_next;
   reg  [4:0]       phy_reg;
   reg  [4:0]       phy_next;
   reg  [4:0]       regad_reg;
   reg  [1:0]       st_reg;
   reg  [1:0]       op_reg;
   reg              run_d_reg;
   reg              done_pass_reg;
   reg              done_pass_next;
   reg  [31:0]      latest_match_next;
   reg  [31:0]      latest_valid_next;
   reg  [31:0]      sticky_next;
   reg              active_next;
   reg  [DIV_W-1:0] half_reg;
   wire             is_read;
   wire             run;
   wire             run_rise;
   wire             start;
   wire             busy;
   wire             done;
   wire [15:0]      rdata;
   wire             ok;
   wire             mism;
   wire [31:0]      phy_bit;
   wire             last_phy;

   // ------------------------------------------------------------
   // Scan start condition
   // ------------------------------------------------------------
   // Read for Clause 22 by default, Clause 45 read codes otherwise
   assign is_read  = (i_frame_start_code == `PSCM_ST_C45) ?
                     (i_operation_code == `PSCM_OP_C45_READ ||
                      i_operation_code == `PSCM_OP_C45_RDINC) :
                     (i_operation_code == `PSCM_OP_C22_READ);  // RQ18
   assign run      = i_scan_enable & is_read;                 // RQ4
   // A finished one-pass run restarts only after enable or the read
   // code has dropped and come back, seen here as a rising edge
   assign run_rise = run & ~run_d_reg;                        // RQ4
   assign start    = (state_reg == S_LAUNCH);

   // ------------------------------------------------------------
   // Result comparison
   // ------------------------------------------------------------
   // Only bit positions with a mask of one can differ
   assign mism     = |((rdata ^ i_expected_value) & i_compare_mask); // RQ7 RQ8
   // One-hot select of the PHY in flight, and the end of the range
   assign phy_bit  = `PSCM_ONE_HOT_PHY << phy_reg;
   assign last_phy = (phy_reg == i_phy_high);

   // ------------------------------------------------------------
   // Divider clamp so MDC never runs above its ceiling
   // ------------------------------------------------------------
   // Small dividers are raised to the floor; the compare runs at 32
   // bits so the carry is kept there. A divider of all ones wraps the
   // half period to zero, which the frame engine counts as the full
   // 2**DIV_W cycles, so the slowest setting stays usable.
   always @(posedge i_clk) begin
      if (i_srst)
         half_reg <= MIN_HALF_W[DIV_W-1:0];
      else if (i_ce) begin
         if (i_clock_divider + 1'b1 < MIN_HALF_W)
            half_reg <= MIN_HALF_W[DIV_W-1:0];               // RQ17
         else
            half_reg <= i_clock_divider + 1'b1;              // RQ17
      end
   end

   // ------------------------------------------------------------
   // Sequencer next state
   // ------------------------------------------------------------
   always @* begin
      // Hold everything unless a branch below moves it
      state_next     = state_reg;
      phy_next       = phy_reg;
      done_pass_next = done_pass_reg;
      active_next    = o_scan_active;
      case (state_reg)
         S_IDLE: begin
            // Enable dropped: forget the finished pass
            if (!run)
               done_pass_next = 1'b0;
            if (run_rise || (run && !done_pass_reg)) begin
               state_next     = S_LAUNCH;
               phy_next       = i_phy_low;                    // RQ2
               done_pass_next = 1'b0;
               active_next    = 1'b1;
            end else begin
               active_next    = 1'b0;
            end
         end
         S_LAUNCH: begin
            state_next = S_WAIT;
         end
         S_WAIT: begin
            if (done) begin
               if (last_phy) begin
                  phy_next = i_phy_low;                       // RQ19
                  if (i_one_pass)
                     done_pass_next = 1'b1;                   // RQ5
               end else begin
                  // Low above high walks up through 31 and wraps at 0
                  phy_next = phy_reg + 5'h01;                 // RQ2
               end
               // Keep going while enabled, unless the pass is over
               if (run && !(last_phy && i_one_pass)) begin
                  state_next = S_LAUNCH;                      // RQ1
               end else begin
                  state_next  = S_IDLE;
                  active_next = 1'b0;
               end
            end
         end
         default: begin
            state_next  = S_IDLE;
            active_next = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Sequencer registers and latched frame fields
   // ------------------------------------------------------------
   always @(posedge i_clk) begin
      if (i_srst) begin
         state_reg     <= S_IDLE;
         phy_reg       <= 5'h00;
         regad_reg     <= 5'h00;
         st_reg        <= `PSCM_ST_C22;
         op_reg        <= `PSCM_OP_C22_READ;
         run_d_reg     <= 1'b0;
         done_pass_reg <= 1'b0;
         o_scan_active <= 1'b0;
      end else if (i_ce) begin
         state_reg     <= state_next;
         phy_reg       <= phy_next;
         run_d_reg     <= run;
         done_pass_reg <= done_pass_next;
         o_scan_active <= active_next;
         // Only the scan fields are taken; the rest are ignored
         // Latched at launch, so edits apply from the next frame
         if (state_next == S_LAUNCH) begin
            regad_reg <= i_scan_reg_addr;                     // RQ3 RQ6
            st_reg    <= i_frame_start_code;                  // RQ18
            op_reg    <= i_operation_code;
         end
      end
   end

   // ------------------------------------------------------------
   // Result registers next values
   // ------------------------------------------------------------
   always @* begin
      latest_match_next = o_scan_latest_match;
      latest_valid_next = o_scan_latest_valid;
      // Read returns the current value, then all ones
      if (i_sticky_rd)
         sticky_next = `PSCM_MATCH_RST;                       // RQ12
      else
         sticky_next = o_scan_sticky_match;
      // A failed read clears valid and never counts as a mismatch
      if (done && state_reg == S_WAIT) begin
         if (ok) begin
            latest_valid_next = o_scan_latest_valid | phy_bit; // RQ10
         end else begin
            latest_valid_next = o_scan_latest_valid & ~phy_bit;// RQ10
         end
         if (ok && mism) begin
            latest_match_next = o_scan_latest_match & ~phy_bit;// RQ9
            // A mismatch in the read cycle is kept
            sticky_next       = sticky_next & ~phy_bit;        // RQ11
         end else begin
            latest_match_next = o_scan_latest_match | phy_bit; // RQ9
         end
      end
   end

   // ------------------------------------------------------------
   // Result registers and interrupt
   // ------------------------------------------------------------
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_scan_latest_match <= `PSCM_MATCH_RST;
         o_scan_latest_valid <= `PSCM_VALID_RST;
         o_scan_sticky_match <= `PSCM_MATCH_RST;
         o_irq               <= 1'b0;
      end else if (i_ce) begin
         o_scan_latest_match <= latest_match_next;
         o_scan_latest_valid <= latest_valid_next;
         o_scan_sticky_match <= sticky_next;
         // Interrupt is the NAND of the next sticky bits
         // Dedicated line, drops with the sticky bits
         o_irq               <= ~&sticky_next;          // RQ13 RQ14 RQ15
      end
   end

   // ------------------------------------------------------------
   // Management frame engine
   // ------------------------------------------------------------
   // Launch pulses start; done pulses once, on the last MDC fall
   // When idle the engine keeps MDC low and the data line released
   pscm_mdio_frame #(
      .DIV_W      (DIV_W)
   ) u_frame (
      .i_clk      (i_clk),
      .i_srst     (i_srst),
      .i_ce       (i_ce),
      .i_start    (start),
      .i_half     (half_reg),
      .i_st       (st_reg),
      .i_op       (op_reg),
      .i_phy      (phy_reg),
      .i_reg      (regad_reg),
      .i_mdio_in  (i_mdio_in),
      .o_busy     (busy),
      .o_done     (done),
      .o_rdata    (rdata),
      .o_ok       (ok),
      .o_mdc      (o_mdc),
      .o_mdio_out (o_mdio_out),
      .o_mdio_oe  (o_mdio_oe)
   );

endmodule // pscm_scan_monitor

`default_nettype wire

//--- sim/pscm_scan_monitor_monitor.sv
// Port checker for the PHY scan monitor, bound to its top module
`default_nettype none
module pscm_scan_chk (
   input wire logic        i_clk,               // Core clock
   input wire logic        i_srst,              // Synchronous reset
   input wire logic        i_scan_enable,       // Scan enable
   input wire logic [1:0]  i_operation_code,    // Operation field
   input wire logic        i_sticky_rd,         // Sticky read pulse
   input wire logic [31:0] o_scan_latest_match, // Latest results
   input wire logic [31:0] o_scan_latest_valid, // Latest valid
   input wire logic [31:0] o_scan_sticky_match, // Sticky results
   input wire logic        o_irq,               // Interrupt
   input wire logic        o_scan_active,       // Scan running
   input wire logic        o_mdc,               // Management clock
   input wire logic        o_mdio_out,          // Data value
   input wire logic        o_mdio_oe            // Data enable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // ------------------------------------------------------------
   // Result registers and interrupt
   // ------------------------------------------------------------
   irq_from_sticky_a: assert property (
      o_irq == (o_scan_sticky_match != 32'hFFFF_FFFF))
      else $error("irq does not follow sticky state");
   sticky_read_a: assert property (
      i_sticky_rd |=> (~o_scan_sticky_match & o_scan_latest_match) == 0)
      else $error("sticky read left stale clear bits");
   sticky_hold_a: assert property (
      !i_sticky_rd |=>
      (o_scan_sticky_match & ~$past(o_scan_sticky_match)) == 0)
      else $error("sticky bit set without a read");
   sticky_set_a: assert property (
      (~o_scan_latest_match & $past(o_scan_latest_match)
       & o_scan_sticky_match) == 0)
      else $error("mismatch not copied to sticky");
   fail_match_a: assert property (
      (~o_scan_latest_valid & ~o_scan_latest_match) == 0)
      else $error("failed read flagged as mismatch");
   // ------------------------------------------------------------
   // Management pins
   // ------------------------------------------------------------
   drive_in_scan_a: assert property (
      o_mdio_oe |-> o_scan_active)
      else $error("data driven outside a scan");
   change_on_fall_a: assert property (
      o_mdio_oe && $past(o_mdio_oe) && $changed(o_mdio_out) |-> $fell(o_mdc))
      else $error("data changed off the clock fall");
   release_on_fall_a: assert property (
      $fell(o_mdio_oe) |-> $fell(o_mdc))
      else $error("data released off the clock fall");
   mdc_high_a: assert property (
      $rose(o_mdc) |-> o_mdc [*5])
      else $error("clock high phase too short");
   mdc_low_a: assert property (
      $fell(o_mdc) |-> !o_mdc [*5])
      else $error("clock low phase too short");
   start_frame_a: assert property (
      $rose(o_scan_active) |=> o_mdio_oe && o_mdio_out && !o_mdc)
      else $error("frame not launched after start");
   start_cause_a: assert property (
      $rose(o_scan_active) |-> $past(i_scan_enable && i_operation_code[1]))
      else $error("scan started without read enable");
   cover property ($rose(o_scan_active));
   cover property ($rose(o_irq));
   cover property (i_sticky_rd && o_irq);
endmodule // pscm_scan_chk

bind pscm_scan_monitor pscm_scan_chk u_chk (
   .i_clk(i_clk), .i_srst(i_srst), .i_scan_enable(i_scan_enable),
   .i_operation_code(i_operation_code), .i_sticky_rd(i_sticky_rd),
   .o_scan_latest_match(o_scan_latest_match),
   .o_scan_latest_valid(o_scan_latest_valid),
   .o_scan_sticky_match(o_scan_sticky_match), .o_irq(o_irq),
   .o_scan_active(o_scan_active), .o_mdc(o_mdc),
   .o_mdio_out(o_mdio_out), .o_mdio_oe(o_mdio_oe));
`default_nettype wire

//--- sim/pscm_phy_model.sv
// Behavioural set of PHYs answering read frames on the management bus
`default_nettype none
module pscm_phy_model (
   input  wire logic        i_mdc,       // Management clock
   input  wire logic        i_mdio,      // Resolved data line
   input  wire logic        i_oe,        // Controller drive enable
   input  var  logic [15:0] i_resp [32], // Register value per PHY
   input  wire logic [31:0] i_absent,    // PHYs that never answer
   output var  logic        o_oe = 0,    // PHY drive enable
   output var  logic        o_out = 1,   // PHY drive value
   output var  logic [13:0] o_hdr = 0,   // ST OP PHY REG seen
   output var  int          o_frames = 0 // Headers seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [13:0] sh = 0;
   logic [4:0]  pa = 0;
   int          cnt = 0;
   logic        armed = 0;
   // Controller bits taken at MDC rise, mid-bit
   always @(posedge i_mdc) begin
      if (!armed && i_oe) begin
         armed = 1'b1;
         cnt = 0;
      end
      if (armed) begin
         sh = {sh[12:0], i_mdio};
         cnt = cnt + 1;
      end
   end
   // Answer changes after MDC fall, held over the next sample
   always @(negedge i_mdc) begin
      if (armed) begin
         if (cnt == 46) begin
            pa = sh[9:5];
            o_hdr <= sh;
            o_frames <= o_frames + 1;
         end
         o_oe <= cnt >= 47 && cnt <= 63 && !i_absent[pa];
         o_out <= (cnt == 47) ? 1'b0 : i_resp[pa][(63 - cnt) & 15];
         if (cnt == 64)
            armed = 1'b0;
      end
   end
endmodule // pscm_phy_model
`default_nettype wire

//--- sim/pscm_scan_monitor_tb_top.sv
// Self-checking bench for the PHY scan monitor
`default_nettype none
module pscm_scan_monitor_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, srst = 1, en = 0, onep = 0, rd = 0;
   logic [1:0]  op = 2'h2, st = 2'h1;
   logic [4:0]  ra = 0, lo = 0, hi = 0;
   logic [15:0] exp_v = 0, mask_v = 0;
   logic [7:0]  div = 0;
   logic [15:0] resp [32];
   logic [31:0] absent = 0, vis = 0, latest, valid, sticky;
   logic [31:0] e_lat = 32'hFFFF_FFFF, e_val = 0;
   logic        irq, act, mdc, mdo, oe, p_oe, p_out, mdio;
   logic [13:0] hdr;
   int          frames, fails = 0, n_compared = 0, cyc = 0;
   integer      seed = 32'he4ec_b1ec;
   always #2 clk = ~clk;
   assign mdio = oe ? mdo : (p_oe ? p_out : 1'b1);
   pscm_scan_monitor u_pscm_scan_monitor (
      .i_clk(clk), .i_srst(srst), .i_ce(1'b1), .i_scan_enable(en),
      .i_one_pass(onep), .i_operation_code(op), .i_frame_start_code(st),
      .i_scan_reg_addr(ra), .i_phy_low(lo), .i_phy_high(hi),
      .i_expected_value(exp_v), .i_compare_mask(mask_v),
      .i_clock_divider(div), .i_sticky_rd(rd), .i_mdio_in(mdio),
      .o_scan_latest_match(latest), .o_scan_latest_valid(valid),
      .o_scan_sticky_match(sticky), .o_irq(irq), .o_scan_active(act),
      .o_mdc(mdc), .o_mdio_out(mdo), .o_mdio_oe(oe));
   pscm_phy_model u_pscm_phy_model (
      .i_mdc(mdc), .i_mdio(mdio), .i_oe(oe), .i_resp(resp),
      .i_absent(absent), .o_oe(p_oe), .o_out(p_out), .o_hdr(hdr),
      .o_frames(frames));
   // Expected match vector for visited PHYs
   function automatic logic [31:0] exp_m(input logic [31:0] v);
      logic [31:0] m;
      m = 32'hFFFF_FFFF;
      for (int p = 0; p < 32; p++)
         if (v[p] && !absent[p] && ((resp[p] ^ exp_v) & mask_v) != 0)
            m[p] = 1'b0;
      return m;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wrap_up();
      if (fails == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Follows n frames from l, wrapping at h
   task automatic scan(input logic [4:0] l, h, input int n);
      logic [4:0] p;
      int f;
      p = l;
      vis = 0;
      for (int i = 0; i < n; i++) begin
         f = frames;
         while (frames == f) @(posedge clk);
         chk("header", {st, op, p, ra}, 32'(hdr));
         vis[p] = 1'b1;
         p = (p == h) ? l : p + 5'h01;
      end
   endtask
   // Waits for idle, then no frame may follow
   task automatic stopped(input string nm);
      int f;
      while (act === 1'b1) @(posedge clk);
      f = frames;
      repeat (1500) @(posedge clk);
      chk(nm, f, frames);
   endtask
   task automatic results();
      // Bits of PHYs not visited this time keep their earlier values
      e_lat = (e_lat | vis) & exp_m(vis);
      e_val = (e_val & ~vis) | (vis & ~absent);
      @(negedge clk);
      chk("latest", e_lat, latest);
      chk("valid", e_val, valid);
      chk("sticky", exp_m(vis), sticky);
      chk("irq", 32'(exp_m(vis) != 32'hFFFF_FFFF), 32'(irq));
      @(posedge clk);
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk("sticky read", 32'hFFFF_FFFF, sticky);
      chk("irq read", 0, 32'(irq));
      @(posedge clk);
   endtask
   // Cycle ceiling against hangs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      for (int p = 0; p < 32; p++)
         resp[p] = $random(seed);
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      exp_v <= $random(seed);
      mask_v <= $random(seed) | 16'h0100;
      ra <= $random(seed);
      div <= $random(seed) & 8'h07;
      lo <= 5'h03;
      hi <= 5'h06;
      onep <= 1'b1;
      absent <= 32'h0000_0020;
      // Write operation with enable must not scan
      op <= 2'h1;
      en <= 1'b1;
      repeat (200) @(posedge clk);
      chk("no write scan", 0, frames);
      resp[3] = exp_v ^ ~mask_v;
      resp[4] = exp_v ^ (mask_v & -mask_v);
      op <= 2'h2;
      scan(5'h03, 5'h06, 4);
      stopped("one pass");
      results();
      // Continuous Clause 45 scan wrapping through 31 and 0
      en <= 1'b0;
      absent <= 0;
      onep <= 1'b0;
      st <= 2'h0;
      op <= {1'b1, 1'($random(seed))};
      div <= 8'h02;
      lo <= 5'h1E;
      hi <= 5'h01;
      @(posedge clk);
      en <= 1'b1;
      scan(5'h1E, 5'h01, 6);
      en <= 1'b0;
      stopped("enable drop");
      results();
      wrap_up();
   end
endmodule // pscm_scan_monitor_tb_top
`default_nettype wire
